/* File: core/ftbsp_defs.vh */
// constants for the flow-through burst sram port
`ifndef FTBSP_DEFS_VH
`define FTBSP_DEFS_VH
`define FTBSP_ADDR_W      18
`define FTBSP_DATA_W      32
`define FTBSP_LANES       4
`define FTBSP_BURST_W     2
`define FTBSP_RST_BURST   2'h0
`define FTBSP_RST_ADDR    18'h00000
`define FTBSP_SLEEP_CYC   2
`endif

/* File: core/ftbsp_burst_gen.v */
// burst address sequencer: linear or interleaved two-bit order
`default_nettype none
module ftbsp_burst_gen #(
  parameter BW = 2
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          load,
  input  wire [BW-1:0] start,
  input  wire          advance,
  input  wire          interleave,
  output wire [BW-1:0] addr
);
  reg [BW-1:0] start_reg;
  reg [BW-1:0] count_reg;
  // count after this edge: an advancing edge already accesses the next address
  wire [BW-1:0] step_cnt = advance ? count_reg + {{(BW-1){1'b0}}, 1'b1} : count_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_reg <= {BW{1'b0}};
      count_reg <= {BW{1'b0}};
    end else if (load) begin
      start_reg <= start; // RULE_05
      count_reg <= {BW{1'b0}};
    end else if (advance) begin
      count_reg <= step_cnt; // RULE_09
    end
  end

  // wraps inside the low bits only
  assign addr = interleave ? (start_reg ^ step_cnt) // RULE_19
                           : (start_reg + step_cnt); // RULE_20
endmodule // ftbsp_burst_gen
`default_nettype wire

/* File: core/ftbsp_sram_port.v */
// flow-through burst sram port: 256K x 32 with byte lanes and burst counter
`default_nettype none
`include "ftbsp_defs.vh"
// What this block does
// RULE_01: address and chip selects registered only when an address strobe is active.
// RULE_02: burst order strap high gives interleaved order, low gives linear order.
// RULE_03: two-bit burst counter takes start address and makes following addresses.
// RULE_04: registered address selects one of 256K words when selected.
// RULE_05: each new address loads its two low bits into the burst counter.
// RULE_06: byte lane selects are active low, used only with byte write enable.
// RULE_07: global write low writes all four bytes regardless of lane selects.
// RULE_08: controller drives byte write enable low with wanted lane selects.
// RULE_09: burst counter steps on each edge with advance sampled low.
// RULE_10: primary select high makes the processor strobe ignored.
// RULE_11: selected only when expand high is high and expand low is low.
// RULE_12: chip selects sampled only when a new external address loads.
// RULE_13: data pins drive while output enable is low, tri-state when high.
// RULE_14: first read clock after deselect keeps data pins undriven.
// RULE_15: both strobes low means only the processor strobe acts.
// RULE_16: sleep high enters low power, keeping stored contents.
// RULE_17: write data registered on the edge; reads flow through from registered address.
// RULE_18: output enable and sleep are asynchronous; others synchronous to the clock.
// RULE_19: interleaved order is start exclusive-or count.
// RULE_20: linear order adds one modulo four on each advance.
// RULE_21: processor strobe start cycle ignores write controls; next edge decides write.
// RULE_22: data pins tri-state once a write is detected, whatever output enable.
// RULE_23: upper address bits stay fixed during a burst; only low bits wrap.
// RULE_24: access with any chip select inactive does no read or write; a deselecting strobe in a burst still writes when write controls are active.
// RULE_25: lane A gates bits 7 to 0, lanes B, C, D successive bytes.
module ftbsp_sram_port #(
  parameter AW    = `FTBSP_ADDR_W,
  parameter DW    = `FTBSP_DATA_W,
  parameter LANES = `FTBSP_LANES
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire [AW-1:0]    addr_in,
  input  wire             processor_addr_strobe_n,
  input  wire             controller_addr_strobe_n,
  input  wire             burst_advance_n,
  input  wire             chip_select_primary_n,
  input  wire             chip_select_expand_hi,
  input  wire             chip_select_expand_lo_n,
  input  wire             global_write_n,
  input  wire             byte_write_enable_n,
  input  wire [LANES-1:0] byte_lane_select_n,
  input  wire             output_enable_n,
  input  wire             sleep_request,
  input  wire             burst_order_interleave,
  input  wire [DW-1:0]    data_in,
  output wire [DW-1:0]    data_out,
  output wire             data_oe,
  output wire             sleep_active
);
  localparam BW   = `FTBSP_BURST_W;
  localparam LW   = DW / LANES;
  localparam LOGW = AW - BW;

  // one-hot access states
  localparam ST_IDLE  = 3'b001;
  localparam ST_READ  = 3'b010;
  localparam ST_WRITE = 3'b100;

  reg [DW-1:0]   mem [0:(1<<AW)-1];
  reg [2:0]      state_reg;
  reg [2:0]      state_next;
  reg [LOGW-1:0] upper_reg;
  reg            first_read_reg;
  reg            ps_start_reg;
  reg [DW-1:0]   rdata_reg;
  reg [1:0]      sleep_cnt_reg;
  reg            sleep_reg;

  wire selected;
  wire ps_load;
  wire cs_load;
  wire load;
  wire desel;
  wire [BW-1:0] burst_addr;
  wire [AW-1:0] cur_addr;
  wire [LANES-1:0] lane_we;
  wire wr_ctl;
  wire wr_now;
  wire advance;
  wire [AW-1:0] acc_addr;
  integer       ln;

  // sleep is asynchronous: blocks loads, burst advances and writes, no reset of memory
  wire awake = ~sleep_request & ~sleep_reg; // RULE_16 RULE_18

  assign selected = ~chip_select_primary_n & chip_select_expand_hi
                    & ~chip_select_expand_lo_n; // RULE_11
  assign ps_load  = awake & ~processor_addr_strobe_n
                    & ~chip_select_primary_n; // RULE_10 RULE_15
  // an ignored processor strobe leaves the controller strobe in charge
  assign cs_load  = awake & ~controller_addr_strobe_n
                    & (processor_addr_strobe_n | chip_select_primary_n); // RULE_10 RULE_15
  // strobe with any select inactive deselects, except a processor strobe with primary select high, which is ignored; selects ignored otherwise
  assign load  = (ps_load | cs_load) & selected; // RULE_01 RULE_04 RULE_12
  assign desel = awake & ((ps_load | cs_load) & ~selected); // RULE_24

  assign wr_ctl  = ~global_write_n | (~byte_write_enable_n & ~&byte_lane_select_n);
  assign lane_we = ~global_write_n ? {LANES{1'b1}} // RULE_07
                 : (byte_write_enable_n ? {LANES{1'b0}}
                    : ~byte_lane_select_n); // RULE_06 RULE_25
  assign advance = awake & ~load & ~burst_advance_n & (state_reg != ST_IDLE);

  ftbsp_burst_gen #(
    .BW(BW)
  ) u_burst (
    .clk        (ref_clk),
    .rst        (sys_rst),
    .load       (load),
    .start      (addr_in[BW-1:0]),
    .advance    (advance),
    .interleave (burst_order_interleave),
    .addr       (burst_addr)
  ); // RULE_02 RULE_03

  assign cur_addr = {upper_reg, burst_addr}; // RULE_23
  assign acc_addr = load ? addr_in : cur_addr;

  // write in this cycle: controller_addr_strobe_n start with write controls, or continuing access
  assign wr_now = awake & wr_ctl & (
                    (load & cs_load) |
                    (~load & (state_reg != ST_IDLE))); // RULE_21

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (!awake || desel)
          state_next = ST_IDLE;
        else if (load)
          state_next = (cs_load && wr_ctl) ? ST_WRITE : ST_READ; // RULE_21
        else if (state_reg != ST_IDLE)
          state_next = wr_ctl ? ST_WRITE : ST_READ;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= ST_IDLE;
      upper_reg      <= {LOGW{1'b0}};
      first_read_reg <= 1'b0;
      ps_start_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ps_start_reg <= load & ps_load;
      if (load)
        upper_reg <= addr_in[AW-1:BW]; // RULE_01 RULE_23
      // first read after a deselected state masks output enable
      first_read_reg <= load & (state_reg == ST_IDLE)
                        & ~(cs_load & wr_ctl); // RULE_14
    end
  end

  // memory: write data registered at the edge, per-lane enables, one writer process
  always @(posedge ref_clk) begin
    for (ln = 0; ln < LANES; ln = ln + 1) begin
      if (wr_now && lane_we[ln])
        mem[acc_addr][ln*LW +: LW] <= data_in[ln*LW +: LW]; // RULE_17 RULE_25
    end
  end

  // read data registered at the same edge that registers or steps its address
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      rdata_reg <= {DW{1'b0}};
    else
      rdata_reg <= mem[acc_addr]; // RULE_17
  end

  // sleep status counts two cycles to enter and exit
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_cnt_reg <= 2'h0;
      sleep_reg     <= 1'b0;
    end else if (sleep_request != sleep_reg) begin
      if (sleep_cnt_reg == `FTBSP_SLEEP_CYC - 1) begin
        sleep_reg     <= sleep_request; // RULE_16
        sleep_cnt_reg <= 2'h0;
      end else begin
        sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
      end
    end else begin
      sleep_cnt_reg <= 2'h0;
    end
  end

  assign data_out     = rdata_reg;
  assign sleep_active = sleep_reg;
  // output enable acts asynchronously
  assign data_oe = ~output_enable_n & ~sleep_request & ~sleep_reg // RULE_13 RULE_18
                   & (state_reg == ST_READ) & ~first_read_reg // RULE_14
                   & ~(wr_ctl & ~ps_start_reg); // RULE_22
endmodule // ftbsp_sram_port
`default_nettype wire

/* File: dv/ftbsp_port_properties.sv */
// pin-level assertions for the sram port
`default_nettype none
module ftbsp_port_props (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_expand_hi,
  input wire logic chip_select_expand_lo_n,
  input wire logic global_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic sleep_active
);
  timeunit 1ns / 1ns;
  wire ps = !processor_addr_strobe_n;
  wire cs = !controller_addr_strobe_n;
  wire zz = sleep_request | sleep_active;
  wire sel = !chip_select_primary_n & chip_select_expand_hi & !chip_select_expand_lo_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_desel; (cs || (ps && !chip_select_primary_n)) && !sel && !zz; endsequence
  sequence s_pload; ps && sel && !zz; endsequence
  property p_desel; s_desel |=> !data_oe; endproperty
  property p_first; s_desel ##1 s_pload |=> !data_oe; endproperty
  property p_cwr; !ps && cs && sel && !zz && !global_write_n |=> !data_oe; endproperty
  property p_pwr; s_pload ##1 (!ps && !cs && !global_write_n) |=> !data_oe; endproperty
  property p_oe; output_enable_n |-> !data_oe; endproperty
  property p_slpz; sleep_active |-> !data_oe; endproperty
  property p_slp_in; sleep_request [*4] |-> sleep_active; endproperty
  property p_slp_out; !sleep_request [*4] |-> !sleep_active; endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  a_first: assert property (p_first) else $error("first read drives");
  a_cwr: assert property (p_cwr) else $error("drive in write");
  a_pwr: assert property (p_pwr) else $error("drive in late write");
  a_oe: assert property (p_oe) else $error("drive with enable off");
  a_slpz: assert property (p_slpz) else $error("drive in sleep");
  a_slp_in: assert property (p_slp_in) else $error("no sleep");
  a_slp_out: assert property (p_slp_out) else $error("stuck in sleep");
endmodule // ftbsp_port_props
bind ftbsp_sram_port ftbsp_port_props props_u (.*);
`default_nettype wire

/* File: dv/ftbsp_host_model.sv */
// host bus model driving the port's synchronous inputs
`default_nettype none
module ftbsp_host_model (
  input wire logic   clk,
  output logic [8:0]  ctl = 9'h1F7,
  output logic [17:0] a = 18'h0,
  output logic [31:0] wd = 32'h0,
  output logic [3:0]  bl = 4'hF
);
  timeunit 1ns / 1ns;
  // change after the falling edge, hold through the sampling edge
  task cyc(input logic [8:0] c, input logic [17:0] ad, input logic [31:0] d,
           input logic [3:0] b);
    @(negedge clk);
    ctl = c;
    a = ad;
    wd = d;
    bl = b;
    @(posedge clk);
    #1;
  endtask
endmodule // ftbsp_host_model
`default_nettype wire

/* File: dv/flow_through_burst_sram_port_test.sv */
// self-checking bench for the sram port
`default_nettype none
module flow_through_burst_sram_port_test;
  timeunit 1ns / 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ilv = 1'b0;
  logic slp = 1'b0;
  logic oe, sa;
  logic [8:0] c;
  logic [17:0] a;
  logic [31:0] wd, q;
  logic [3:0] bl;
  logic [31:0] m [logic [17:0]];
  int fail_count = 0;
  int total_checks = 0;
  ftbsp_host_model p_u (.clk(ref_clk), .ctl(c), .a(a), .wd(wd), .bl(bl));
  ftbsp_sram_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr_in(a),
    .processor_addr_strobe_n(c[8]), .controller_addr_strobe_n(c[7]), .burst_advance_n(c[6]),
    .chip_select_primary_n(c[5]), .chip_select_expand_hi(c[4]), .chip_select_expand_lo_n(c[3]),
    .global_write_n(c[2]), .byte_write_enable_n(c[1]), .byte_lane_select_n(bl),
    .output_enable_n(c[0]), .sleep_request(slp), .burst_order_interleave(ilv),
    .data_in(oe ? q : wd), .data_out(q), .data_oe(oe), .sleep_active(sa));
  initial forever #5 ref_clk = ~ref_clk;
  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] d, logic [3:0] b);
    for (int j = 0; j < 4; j++) if (!b[j]) o[8*j+:8] = d[8*j+:8];
    return o;
  endfunction
  // ps path puts a full write of other data in the load cycle, which must be ignored
  task wr(input logic [17:0] ad, input logic [31:0] d, input logic [3:0] b, input logic g,
          input logic ps, input logic [2:0] s);
    if (ps) begin
      p_u.cyc({3'b011, s, 3'b011}, ad, ~d, 4'h0);
      p_u.cyc({3'b111, s, g, !g, 1'b1}, ad, d, b);
    end else p_u.cyc({3'b101, s, g, !g, 1'b1}, ad, d, b);
    if (s == 3'b010) m[ad] = g ? mrg(m[ad], d, b) : d;
  endtask
  // burst advances with selects off and a foreign address on the pins
  task rd(input logic [17:0] ad);
    logic [17:0] x;
    p_u.cyc(9'h077, ad, $urandom, 4'hF);
    p_u.cyc(9'h052, ad, $urandom, 4'h0);
    check(q, m[ad]);
    check(oe, 1'b0);
    for (int k = 1; k < 4; k++) begin
      p_u.cyc(9'h1AE, ~ad, $urandom, 4'h0);
      x = {ad[17:2], ilv ? ad[1:0] ^ k[1:0] : ad[1:0] + k[1:0]};
      check(q, m[x]);
      check(oe, 1'b1);
    end
  endtask
  initial begin
    logic [17:0] b;
    logic [31:0] d;
    d = $urandom(32'hDFC7);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    for (int r = 0; r < 8; r++) begin
      b = 18'($urandom) & 18'h3FFFC;
      for (int k = 0; k < 4; k++) wr(b + 18'(k), $urandom, 4'h0, 1'b0, k[0], 3'b010);
      d = $urandom;
      wr(b + 18'(d[1:0]), $urandom, d[7:4], 1'b1, d[8], 3'b010);
      // deselect first, so an ignored strobe cannot continue the previous write
      p_u.cyc(9'h077, b, $urandom, 4'hF);
      wr(b + 18'(d[3:2]), $urandom, d[11:8], d[12], d[13], d[16:14]);
      @(negedge ref_clk) ilv = r[0];
      rd(b + 18'(d[21:20]));
    end
    p_u.cyc(9'h177, b, $urandom, 4'hF);
    @(negedge ref_clk) slp = 1'b1;
    repeat (4) p_u.cyc(9'h1F7, b, $urandom, 4'hF);
    check(sa, 1'b1);
    p_u.cyc(9'h153, b, ~m[b], 4'h0);
    @(negedge ref_clk) slp = 1'b0;
    repeat (4) p_u.cyc(9'h1F7, b, $urandom, 4'hF);
    check(sa, 1'b0);
    rd(b);
    test_done;
  end
  initial begin
    #20000;
    fail_count++;
    test_done;
  end
endmodule // flow_through_burst_sram_port_test
`default_nettype wire
